/* port_role_pkg.sv */
// shared types and constants for the switch port role and forwarding block
package port_role_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int TRY_TIME_US = 100;
   localparam int TRY_CYCLES_DEF = (TRY_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int TRY_CNT_W = 16;
   localparam logic [TRY_CNT_W-1:0] TRY_CNT_ONE = 16'h0001;
   localparam logic [TRY_CNT_W-1:0] TRY_CNT_ZERO = 16'h0000;
   // ==========================================================
   // capability bits
   localparam int CAP_W = 4;
   localparam int CAP_LOOP = 0;
   localparam int CAP_ISL = 1;
   localparam int CAP_BRIDGE = 2;
   localparam int CAP_FABRIC = 3;
   localparam logic [CAP_W-1:0] CAPS_NONE = 4'h0;
   localparam logic [CAP_W-1:0] CAPS_BRIDGE_ONLY = 4'h4;
   // ==========================================================
   // address identifier layout
   localparam int ID_W = 24;
   localparam int DOM_HI = 23;
   localparam int DOM_LO = 16;
   localparam int AP_W = 16;
   localparam logic [ID_W-1:0] FC_CTRL_ID = 24'hFFFFFD;
   localparam logic [7:0] WKA_DOMAIN = 8'hFF;
   localparam logic [7:0] DOMAIN_NONE = 8'h00;
   localparam logic [AP_W-1:0] ALLOC_FIRST = 16'h0000;
   localparam logic [AP_W-1:0] ALLOC_LAST = 16'hFFFF;
   localparam logic [AP_W-1:0] ALLOC_STEP = 16'h0001;
   localparam logic [ID_W-1:0] ID_NONE = 24'h000000;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ROLE_OFF, ROLE_LOOP, ROLE_ISL, ROLE_BRIDGE, ROLE_FABRIC
   } role_t;
   typedef enum logic [2:0] {
      PEER_NONE, PEER_NODE, PEER_LOOP_NODE, PEER_ISL, PEER_BRIDGE
   } peer_t;
   typedef enum logic [1:0] {CLS_F, CLS_2, CLS_3, CLS_OTHER} class_t;
   typedef enum logic [1:0] {RT_DROP, RT_CTRL, RT_LOCAL, RT_ISL} route_t;
   typedef enum logic [1:0] {SEL_NONE, SEL_SW, SEL_FC} txsel_t;
   typedef struct packed {
      logic sof;
      logic eof;
      logic [31:0] data;
   } word_t;
   localparam word_t WORD_IDLE = '{sof: 1'b0, eof: 1'b0, data: 32'h00000000};
endpackage

/* port_role_switch.sv */
// port role selection, frame routing and frame-boundary transmit switching
`timescale 1ns/1ps
// Function
// - try loop, then inter-switch/bridge, then fabric
// - keep assigned role until re-initialization
// - choose inter-switch or fabric role during initialization
// - bridge device supports only bridge role
// - exchange frames only with allowed peer type
// - routing changes only at frame boundaries
// - keep outbound word alignment intact
// - each frame or connection change is switching event
// - non-local frames leave by inter-switch port
// - attach ports carry internal fabric traffic both ways
// - at least two ports, one inter-switch capable
// - route class F, 2 and 3 frames
// - own domain, allocate area and port identifiers
// - controller address goes to local fabric controller
module port_role_switch #(
   parameter int TRY_CYCLES = port_role_pkg::TRY_CYCLES_DEF
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic [port_role_pkg::CAP_W-1:0] PORT_CAPS,
   input wire logic BRIDGE_DEVICE,
   input wire logic INIT_START,
   input wire logic INIT_OK,
   input wire logic INIT_FAIL,
   input wire port_role_pkg::peer_t INIT_PEER,
   output port_role_pkg::role_t TRY_ROLE,
   output logic TRY_ACTIVE,
   output port_role_pkg::role_t PORT_ROLE,
   output logic PORT_UP,
   output logic PORT_ISOLATED,
   input wire port_role_pkg::word_t RX_WORD,
   input wire logic RX_VALID,
   input wire logic [port_role_pkg::ID_W-1:0] RX_DID,
   input wire port_role_pkg::class_t RX_CLASS,
   output port_role_pkg::word_t RX_FWD_WORD,
   output logic RX_FWD_VALID,
   output port_role_pkg::route_t RX_ROUTE,
   input wire port_role_pkg::word_t SW_WORD,
   input wire logic SW_VALID,
   output logic SW_READY,
   input wire port_role_pkg::word_t FC_WORD,
   input wire logic FC_VALID,
   output logic FC_READY,
   output port_role_pkg::word_t TX_WORD,
   output logic TX_VALID,
   input wire logic CONN_EVT,
   output logic SWITCH_EVT,
   input wire logic DOMAIN_GRANT,
   input wire logic [7:0] DOMAIN_ID,
   input wire logic ALLOC_REQ,
   output logic [7:0] LOCAL_DOMAIN,
   output logic DOMAIN_VALID,
   output logic [port_role_pkg::ID_W-1:0] ALLOC_ID,
   output logic ALLOC_ACK
);
   import port_role_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_TRY, ST_ACTIVE, ST_ISOLATED} state_t;

   // ==========================================================
   // strap synchronisers
   logic [CAP_W-1:0] caps_meta_reg;
   logic [CAP_W-1:0] caps_reg;
   logic bridge_meta_reg;
   logic bridge_reg;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         caps_meta_reg <= CAPS_NONE;
         caps_reg <= CAPS_NONE;
         bridge_meta_reg <= 1'b0;
         bridge_reg <= 1'b0;
      end else if (CLK_EN) begin
         caps_meta_reg <= PORT_CAPS;
         caps_reg <= caps_meta_reg;
         bridge_meta_reg <= BRIDGE_DEVICE;
         bridge_reg <= bridge_meta_reg;
      end
   end

   // ==========================================================
   // mode search order
   wire logic [CAP_W-1:0] caps_eff;
   // a bridge device never offers any other mode
   assign caps_eff = bridge_reg ? CAPS_BRIDGE_ONLY : caps_reg;

   // first supported mode after cur, in the fixed try order
   function automatic role_t next_role(input logic [CAP_W-1:0] c, input role_t cur);
      role_t r;
      r = ROLE_OFF;
      case (cur)
         ROLE_OFF: begin
            if (c[CAP_LOOP]) r = ROLE_LOOP;
            else if (c[CAP_ISL]) r = ROLE_ISL;
            else if (c[CAP_BRIDGE]) r = ROLE_BRIDGE;
            else if (c[CAP_FABRIC]) r = ROLE_FABRIC;
         end
         ROLE_LOOP: begin
            if (c[CAP_ISL]) r = ROLE_ISL;
            else if (c[CAP_BRIDGE]) r = ROLE_BRIDGE;
            else if (c[CAP_FABRIC]) r = ROLE_FABRIC;
         end
         ROLE_ISL: begin
            if (c[CAP_BRIDGE]) r = ROLE_BRIDGE;
            else if (c[CAP_FABRIC]) r = ROLE_FABRIC;
         end
         ROLE_BRIDGE: begin
            if (c[CAP_FABRIC]) r = ROLE_FABRIC;
         end
         default: r = ROLE_OFF;
      endcase
      return r;
   endfunction

   // peer type that each role may talk to
   function automatic logic peer_ok(input role_t r, input peer_t p);
      logic ok;
      ok = 1'b0;
      case (r)
         ROLE_FABRIC: ok = (p == PEER_NODE);
         ROLE_LOOP: ok = (p == PEER_LOOP_NODE);
         ROLE_ISL: ok = (p == PEER_ISL) || (p == PEER_BRIDGE);
         ROLE_BRIDGE: ok = (p == PEER_ISL);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ==========================================================
   // role state machine
   state_t state_reg;
   state_t state_next;
   role_t try_reg;
   role_t try_next;
   role_t role_reg;
   role_t role_next;
   logic [TRY_CNT_W-1:0] tmr_reg;
   logic [TRY_CNT_W-1:0] tmr_next;

   wire role_t first_role;
   wire role_t after_role;
   wire logic try_pass;
   wire logic try_miss;
   wire logic tmr_done;

   assign first_role = next_role(caps_eff, ROLE_OFF);
   assign after_role = next_role(caps_eff, try_reg);
   // a wrong peer counts as a failed attempt
   assign try_pass = INIT_OK && peer_ok(try_reg, INIT_PEER);
   assign tmr_done = (tmr_reg == TRY_CNT_ONE);
   assign try_miss = INIT_FAIL || (INIT_OK && !try_pass) || tmr_done;

   always_comb begin
      state_next = state_reg;
      try_next = try_reg;
      role_next = role_reg;
      tmr_next = (tmr_reg == TRY_CNT_ZERO) ? TRY_CNT_ZERO : tmr_reg - TRY_CNT_ONE;
      case (state_reg)
         ST_IDLE, ST_ACTIVE, ST_ISOLATED: begin
            // role only changes on a fresh initialization
            if (INIT_START) begin
               role_next = ROLE_OFF;
               try_next = first_role;
               tmr_next = TRY_CNT_W'(TRY_CYCLES);
               state_next = (first_role == ROLE_OFF) ? ST_ISOLATED : ST_TRY;
            end
         end
         ST_TRY: begin
            if (try_pass) begin
               role_next = try_reg;
               tmr_next = TRY_CNT_ZERO;
               state_next = ST_ACTIVE;
            end else if (try_miss) begin
               try_next = after_role;
               tmr_next = TRY_CNT_W'(TRY_CYCLES);
               if (after_role == ROLE_OFF) begin
                  tmr_next = TRY_CNT_ZERO;
                  state_next = ST_ISOLATED;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= ST_IDLE;
         try_reg <= ROLE_OFF;
         role_reg <= ROLE_OFF;
         tmr_reg <= TRY_CNT_ZERO;
      end else if (CLK_EN) begin
         state_reg <= state_next;
         try_reg <= try_next;
         role_reg <= role_next;
         tmr_reg <= tmr_next;
      end
   end

   wire logic up;
   assign up = (state_reg == ST_ACTIVE);
   assign TRY_ROLE = try_reg;
   assign PORT_ROLE = role_reg;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TRY_ACTIVE <= 1'b0;
         PORT_UP <= 1'b0;
         PORT_ISOLATED <= 1'b0;
      end else if (CLK_EN) begin
         TRY_ACTIVE <= (state_next == ST_TRY);
         PORT_UP <= (state_next == ST_ACTIVE);
         PORT_ISOLATED <= (state_next == ST_ISOLATED);
      end
   end

   // ==========================================================
   // address manager
   logic [AP_W-1:0] alloc_reg;
   wire logic alloc_take;
   // running out of identifiers refuses further requests silently
   // a grant in the same cycle wins, so no ack with a stale identifier
   assign alloc_take = ALLOC_REQ && DOMAIN_VALID && !DOMAIN_GRANT &&
                       (alloc_reg != ALLOC_LAST);

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LOCAL_DOMAIN <= DOMAIN_NONE;
         DOMAIN_VALID <= 1'b0;
         alloc_reg <= ALLOC_FIRST;
         ALLOC_ID <= ID_NONE;
         ALLOC_ACK <= 1'b0;
      end else if (CLK_EN) begin
         ALLOC_ACK <= alloc_take;
         if (DOMAIN_GRANT) begin
            LOCAL_DOMAIN <= DOMAIN_ID;
            DOMAIN_VALID <= 1'b1;
            alloc_reg <= ALLOC_FIRST;
         end else if (alloc_take) begin
            ALLOC_ID <= {LOCAL_DOMAIN, alloc_reg};
            alloc_reg <= alloc_reg + ALLOC_STEP;
         end
      end
   end

   // ==========================================================
   // receive routing
   wire logic cls_ok;
   wire logic [7:0] did_dom;
   wire route_t rt_sof;
   route_t rt_reg;

   assign cls_ok = (RX_CLASS != CLS_OTHER);
   assign did_dom = RX_DID[DOM_HI:DOM_LO];
   // controller address lands on this switch's controller while the port is up and the class is F, 2 or 3
   assign rt_sof = (!up || !cls_ok) ? RT_DROP :
                   (RX_DID == FC_CTRL_ID) ? RT_CTRL :
                   (did_dom == LOCAL_DOMAIN || did_dom == WKA_DOMAIN) ? RT_LOCAL :
                   RT_ISL;
   wire route_t rt_cur;
   // decision is held for the whole frame
   assign rt_cur = RX_WORD.sof ? rt_sof : rt_reg;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rt_reg <= RT_DROP;
         RX_ROUTE <= RT_DROP;
         RX_FWD_WORD <= WORD_IDLE;
         RX_FWD_VALID <= 1'b0;
      end else if (CLK_EN) begin
         RX_FWD_VALID <= RX_VALID && (rt_cur != RT_DROP);
         if (RX_VALID) begin
            rt_reg <= rt_cur;
            RX_ROUTE <= rt_cur;
            RX_FWD_WORD <= RX_WORD;
         end
      end
   end

   // ==========================================================
   // transmit switching
   txsel_t sel_reg;
   txsel_t sel_next;
   wire logic sw_take;
   wire logic fc_take;
   wire word_t tx_in;

   assign sw_take = SW_READY && SW_VALID;
   assign fc_take = FC_READY && FC_VALID;
   assign tx_in = fc_take ? FC_WORD : SW_WORD;

   // grant moves only once the current frame's last word has left
   always_comb begin
      sel_next = sel_reg;
      case (sel_reg)
         SEL_NONE: begin
            if (up && FC_VALID) sel_next = SEL_FC;
            else if (up && SW_VALID) sel_next = SEL_SW;
         end
         SEL_SW: if (sw_take && SW_WORD.eof) sel_next = SEL_NONE;
         SEL_FC: if (fc_take && FC_WORD.eof) sel_next = SEL_NONE;
         default: sel_next = SEL_NONE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sel_reg <= SEL_NONE;
         SW_READY <= 1'b0;
         FC_READY <= 1'b0;
      end else if (CLK_EN) begin
         sel_reg <= sel_next;
         SW_READY <= (sel_next == SEL_SW);
         FC_READY <= (sel_next == SEL_FC);
      end
   end

   // whole words pass one for one, never split or padded
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TX_WORD <= WORD_IDLE;
         TX_VALID <= 1'b0;
         SWITCH_EVT <= 1'b0;
      end else if (CLK_EN) begin
         TX_VALID <= sw_take || fc_take;
         if (sw_take || fc_take) TX_WORD <= tx_in;
         SWITCH_EVT <= ((sw_take || fc_take) && tx_in.sof) || CONN_EVT;
      end
   end
endmodule

/* port_role_switch_asserts.sv */
// concurrent checks on the port role and forwarding block
`timescale 1ns/1ps
// ====================================
// checker
module port_role_checker #(
   parameter int TRY_CYCLES = port_role_pkg::TRY_CYCLES_DEF
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic BRIDGE_DEVICE,
   input wire logic INIT_START,
   input wire logic INIT_OK,
   input wire port_role_pkg::peer_t INIT_PEER,
   input wire logic TRY_ACTIVE,
   input wire port_role_pkg::role_t PORT_ROLE,
   input wire logic PORT_UP,
   input wire logic PORT_ISOLATED,
   input wire logic RX_VALID,
   input wire logic RX_FWD_VALID,
   input wire port_role_pkg::word_t SW_WORD,
   input wire logic SW_VALID,
   input wire logic SW_READY,
   input wire port_role_pkg::word_t FC_WORD,
   input wire logic FC_VALID,
   input wire logic FC_READY,
   input wire port_role_pkg::word_t TX_WORD,
   input wire logic TX_VALID,
   input wire logic CONN_EVT,
   input wire logic SWITCH_EVT,
   input wire logic DOMAIN_VALID,
   input wire logic DOMAIN_GRANT,
   input wire logic ALLOC_REQ,
   input wire logic [7:0] LOCAL_DOMAIN,
   input wire logic [23:0] ALLOC_ID,
   input wire logic ALLOC_ACK
);
   import port_role_pkg::*;
   logic take_sw;
   logic take_fc;
   assign take_sw = SW_VALID && SW_READY;
   assign take_fc = FC_VALID && FC_READY;
   function automatic bit pair_ok(role_t r, peer_t p);
      return (r == ROLE_FABRIC && p == PEER_NODE) || (r == ROLE_LOOP && p == PEER_LOOP_NODE)
         || (r == ROLE_ISL && (p == PEER_ISL || p == PEER_BRIDGE))
         || (r == ROLE_BRIDGE && p == PEER_ISL);
   endfunction
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // ====================================
   // role selection
   a_role_held: assert property (PORT_UP && !INIT_START |=> PORT_UP && $stable(PORT_ROLE))
      else $error("role changed without a new initialization");
   a_bridge_only: assert property ($rose(PORT_UP) && BRIDGE_DEVICE |-> PORT_ROLE == ROLE_BRIDGE)
      else $error("bridge device came up in another role");
   a_peer_allowed: assert property ($rose(PORT_UP) |-> $past(INIT_OK)
      && pair_ok(PORT_ROLE, $past(INIT_PEER))) else $error("port up with wrong peer");
   a_start_tries: assert property (INIT_START && !TRY_ACTIVE |=> TRY_ACTIVE || PORT_ISOLATED)
      else $error("start did not begin an attempt");
   a_isolated_off: assert property (PORT_ISOLATED |-> !PORT_UP && !TRY_ACTIVE)
      else $error("isolated port is up or trying");
   a_rx_drop: assert property (RX_VALID && !PORT_UP |=> !RX_FWD_VALID)
      else $error("word forwarded while port down");
   // ====================================
   // transmit switching
   a_tx_follows: assert property (take_sw || take_fc |=> TX_VALID
      && TX_WORD == $past(take_fc ? FC_WORD : SW_WORD)) else $error("taken word not sent next");
   a_switch_evt: assert property ((take_sw && SW_WORD.sof) || (take_fc && FC_WORD.sof)
      || CONN_EVT |=> SWITCH_EVT) else $error("switching event missing");
   a_frame_gap: assert property (TX_VALID && TX_WORD.eof |=> !TX_VALID)
      else $error("no idle word after frame end");
   a_sof_first: assert property ($rose(TX_VALID) |-> TX_WORD.sof)
      else $error("transmit began mid-frame");
   // ====================================
   // address allocation
   a_alloc_domain: assert property (ALLOC_ACK |-> $past(ALLOC_REQ)
      && ALLOC_ID[23:16] == LOCAL_DOMAIN) else $error("allocation outside own domain");
   a_no_domain: assert property (ALLOC_REQ && !DOMAIN_VALID && !DOMAIN_GRANT |=> !ALLOC_ACK)
      else $error("allocation without a domain");
   c_fabric_up: cover property ($rose(PORT_UP) && PORT_ROLE == ROLE_FABRIC);
   c_isolated: cover property ($rose(PORT_ISOLATED));
   c_alloc: cover property (ALLOC_ACK);
endmodule
bind port_role_switch port_role_checker #(.TRY_CYCLES(TRY_CYCLES)) port_role_checker_inst (.*);

/* port_peer_model.sv */
// far-end port model answering role attempts
`timescale 1ns/1ps
// ====================================
// peer model
module port_peer_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic try_active,
   input wire port_role_pkg::role_t try_role,
   input wire port_role_pkg::role_t want_role,
   input wire port_role_pkg::peer_t peer_kind,
   input wire logic fail_en,
   input wire logic [3:0] delay,
   output logic init_ok,
   output logic init_fail,
   output port_role_pkg::peer_t init_peer
);
   import port_role_pkg::*;
   logic [3:0] wait_reg;
   logic [3:0] wait_next;
   logic fire;
   // fail_en low leaves unwanted modes silent, so the attempt timer must expire
   assign fire = try_active && !init_ok && !init_fail && wait_reg >= delay;
   assign wait_next = (try_active && !fire) ? wait_reg + 4'h1 : 4'h0;
   // peer code only meaningful with ok, otherwise a moving pattern
   assign init_peer = init_ok ? peer_kind : peer_t'(wait_reg[2:0]);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 4'h0;
         init_ok <= 1'b0;
         init_fail <= 1'b0;
      end else begin
         wait_reg <= wait_next;
         init_ok <= fire && try_role == want_role;
         init_fail <= fire && try_role != want_role && fail_en;
      end
   end
endmodule

/* tb_port_role_switch.sv */
// self-checking bench for the port role and forwarding block
`timescale 1ns/1ps
module tb_port_role_switch;
   import port_role_pkg::*;
   logic REF_CLK, RESET_N, CLK_EN, BRIDGE_DEVICE, INIT_START, INIT_OK, INIT_FAIL, TRY_ACTIVE;
   logic PORT_UP, PORT_ISOLATED, RX_VALID, RX_FWD_VALID, SW_VALID, SW_READY, FC_VALID, fe;
   logic FC_READY, TX_VALID, CONN_EVT, SWITCH_EVT, DOMAIN_GRANT, ALLOC_REQ, DOMAIN_VALID, ALLOC_ACK;
   logic [3:0] PORT_CAPS, dly;
   logic [7:0] DOMAIN_ID, LOCAL_DOMAIN;
   logic [23:0] RX_DID, ALLOC_ID;
   logic [31:0] b1, b2;
   peer_t INIT_PEER, pk;
   role_t TRY_ROLE, PORT_ROLE, want;
   class_t RX_CLASS;
   route_t RX_ROUTE;
   word_t RX_WORD, RX_FWD_WORD, SW_WORD, FC_WORD, TX_WORD;
   word_t exp_w[$], exp_t[$];
   route_t exp_r[$];
   role_t seen[$];
   role_t ord[4] = '{ROLE_LOOP, ROLE_ISL, ROLE_BRIDGE, ROLE_FABRIC};
   int error_cnt, tests_run;
   // ====================================
   // design, far end, clock
   port_role_switch #(.TRY_CYCLES(8)) port_role_switch_inst (.*);
   port_peer_model port_peer_model_inst (.clk(REF_CLK), .rst_n(RESET_N), .try_active(TRY_ACTIVE),
      .try_role(TRY_ROLE), .want_role(want), .peer_kind(pk), .fail_en(fe), .delay(dly),
      .init_ok(INIT_OK), .init_fail(INIT_FAIL), .init_peer(INIT_PEER));
   always #10 REF_CLK = ~REF_CLK;
   // ====================================
   // tasks
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic stall();
      check(34'h1, 34'h0);
      test_done();
   endtask
   task automatic nxt();
      @(negedge REF_CLK);
   endtask
   task automatic init(role_t w, peer_t p, logic [3:0] caps, logic br, logic f, role_t exp);
      int k;
      want = w;
      pk = p;
      PORT_CAPS = caps;
      BRIDGE_DEVICE = br;
      fe = f;
      dly = 4'($urandom_range(3));
      repeat (3) nxt();
      seen.delete();
      INIT_START = 1;
      nxt();
      INIT_START = 0;
      for (k = 0; k < 99 && PORT_UP !== 1 && PORT_ISOLATED !== 1; k++) nxt();
      if (k == 99) stall();
      check(PORT_ROLE, exp);
      check(PORT_ISOLATED, exp == ROLE_OFF);
   endtask
   task automatic rx(logic [23:0] did, class_t c, route_t r);
      logic [31:0] b;
      b = $urandom;
      RX_DID = did;
      RX_CLASS = c;
      for (int i = 0; i < 3; i++) begin
         RX_WORD = '{sof: i == 0, eof: i == 2, data: b + i};
         RX_VALID = 1;
         if (r != RT_DROP) exp_r.push_back(r);
         if (r != RT_DROP) exp_w.push_back(RX_WORD);
         nxt();
      end
      RX_VALID = 0;
      nxt();
   endtask
   task automatic note(logic [31:0] b, int n);
      for (int i = 0; i < n; i++) exp_t.push_back('{sof: i == 0, eof: i == n - 1, data: b + i});
   endtask
   task automatic send(bit fc, logic [31:0] b, int n);
      int k;
      word_t w;
      for (int i = 0; i < n; i++) begin
         w = '{sof: i == 0, eof: i == n - 1, data: b + i};
         if (fc) FC_WORD = w;
         else SW_WORD = w;
         if (fc) FC_VALID = 1;
         else SW_VALID = 1;
         for (k = 0; k < 40 && (fc ? FC_READY : SW_READY) !== 1; k++) nxt();
         if (k == 40) stall();
         nxt();
      end
      if (fc) FC_VALID = 0;
      else SW_VALID = 0;
      nxt();
   endtask
   // ====================================
   // output watcher
   always @(negedge REF_CLK) begin
      if (TRY_ACTIVE === 1 && (seen.size() == 0 || seen[$] !== TRY_ROLE)) seen.push_back(TRY_ROLE);
      if (RX_FWD_VALID === 1 && exp_r.size() == 0) check(RX_FWD_VALID, 0);
      else if (RX_FWD_VALID === 1) begin
         check(RX_FWD_WORD, exp_w.pop_front());
         check(RX_ROUTE, exp_r.pop_front());
      end
      if (TX_VALID === 1 && exp_t.size() == 0) check(TX_VALID, 0);
      else if (TX_VALID === 1) check(TX_WORD, exp_t.pop_front());
   end
   // ====================================
   // main sequence
   initial begin
      REF_CLK = 0;
      {RESET_N, INIT_START, RX_VALID, SW_VALID, FC_VALID, CONN_EVT, DOMAIN_GRANT, ALLOC_REQ} = '0;
      {BRIDGE_DEVICE, fe, PORT_CAPS, dly, DOMAIN_ID, RX_DID, RX_WORD, SW_WORD, FC_WORD} = '0;
      CLK_EN = 1;
      want = ROLE_OFF;
      pk = PEER_NONE;
      RX_CLASS = CLS_F;
      void'($urandom(3519));
      repeat (5) nxt();
      RESET_N = 1;
      nxt();
      check({PORT_UP, PORT_ISOLATED, PORT_ROLE}, {2'b00, ROLE_OFF});
      rx(24'h120000, CLS_2, RT_DROP);
      ALLOC_REQ = 1;
      nxt();
      check(ALLOC_ACK, 0);
      ALLOC_REQ = 0;
      DOMAIN_GRANT = 1;
      DOMAIN_ID = 8'h12;
      nxt();
      DOMAIN_GRANT = 0;
      check({DOMAIN_VALID, LOCAL_DOMAIN}, {1'b1, 8'h12});
      // frozen clock enable must hold off the first allocation
      ALLOC_REQ = 1;
      CLK_EN = 0;
      nxt();
      check(ALLOC_ACK, 0);
      CLK_EN = 1;
      nxt();
      check({ALLOC_ACK, ALLOC_ID}, {1'b1, 8'h12, 16'h0000});
      nxt();
      check({ALLOC_ACK, ALLOC_ID}, {1'b1, 8'h12, 16'h0001});
      ALLOC_REQ = 0;
      init(ROLE_FABRIC, PEER_NODE, 4'hF, 0, 1, ROLE_FABRIC);
      foreach (ord[i]) check(seen[i], ord[i]);
      init(ROLE_LOOP, PEER_LOOP_NODE, 4'hF, 0, 1, ROLE_LOOP);
      init(ROLE_ISL, PEER_BRIDGE, 4'hF, 0, 0, ROLE_ISL);
      init(ROLE_BRIDGE, PEER_ISL, 4'hF, 0, 1, ROLE_BRIDGE);
      init(ROLE_LOOP, PEER_NODE, 4'h1, 0, 1, ROLE_OFF);
      init(ROLE_ISL, PEER_ISL, 4'hF, 1, 1, ROLE_OFF);
      init(ROLE_BRIDGE, PEER_ISL, 4'hF, 1, 1, ROLE_BRIDGE);
      init(ROLE_FABRIC, PEER_NODE, 4'h0, 0, 1, ROLE_OFF);
      init(ROLE_ISL, PEER_ISL, 4'h2, 0, 1, ROLE_ISL);
      rx(FC_CTRL_ID, CLS_F, RT_CTRL);
      rx({8'h12, 16'($urandom)}, CLS_2, RT_LOCAL);
      rx(24'hFFFFFC, CLS_3, RT_LOCAL);
      rx({8'h77, 16'($urandom)}, CLS_3, RT_ISL);
      rx(24'h770001, CLS_OTHER, RT_DROP);
      b1 = $urandom;
      b2 = $urandom;
      note(b1, 2);
      note(b2, 3);
      fork
         send(1, b1, 2);
         send(0, b2, 3);
      join
      note(b2, 2);
      note(b1, 2);
      send(0, b2, 2);
      send(0, b1, 2);
      CONN_EVT = 1;
      nxt();
      CONN_EVT = 0;
      check(SWITCH_EVT, 1);
      // new domain grant beats a request in the same cycle
      DOMAIN_GRANT = 1;
      DOMAIN_ID = 8'h34;
      ALLOC_REQ = 1;
      nxt();
      check(ALLOC_ACK, 0);
      DOMAIN_GRANT = 0;
      nxt();
      check({ALLOC_ACK, ALLOC_ID}, {1'b1, 8'h34, 16'h0000});
      ALLOC_REQ = 0;
      repeat (8) nxt();
      check(exp_t.size() + exp_w.size() + exp_r.size(), 0);
      test_done();
   end
endmodule
